/* File: rtl/table_lookup_interpolator.sv */
`timescale 1ns/10ps
`include "tbl_defs.svh"

module table_lookup_interpolator
  import tbl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire op_t op,
  input wire size_t size,
  input wire logic from_regs,
  input wire logic [31:0] independent_variable_reg,
  input wire logic [31:0] table_base,
  input wire logic [31:0] pair_lo,
  input wire logic [31:0] pair_hi,
  input wire logic [31:0] frame_reg_in,
  input wire logic [31:0] sp_in,
  input wire logic [31:0] link_disp,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic busy,
  output logic done,
  output logic [31:0] result,
  output logic [31:0] sp_out,
  output logic [31:0] frame_reg_out
);

  state_t state_q;
  op_t op_q;
  size_t size_q;
  logic [7:0] frac_q;
  logic [31:0] lo_q;
  logic [31:0] hi_q;
  logic [31:0] disp_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic we_q;
  logic [31:0] result_q;
  logic [31:0] sp_q;
  logic [31:0] frame_q;
  logic [31:0] calc_value;
  logic [7:0] ofs;
  logic accept;

  ////////////////////////////////////////////////////////////////////////////
  // request decode; upper half of the independent variable never read
  assign ofs = independent_variable_reg[`IVR_OFS_MSB:`IVR_OFS_LSB];
  assign accept = (state_q == ST_IDLE) && start;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            if (op == OP_FRAME_LINK)
              state_q <= ST_PUSH;
            else if (op == OP_FRAME_UNLINK)
              state_q <= ST_POP;
            else if (from_regs)
              state_q <= ST_CALC;
            else
              state_q <= ST_READ_LO;
          end
        end
        ST_READ_LO:
          if (mem_ack)
            state_q <= ST_READ_HI;
        ST_READ_HI:
          if (mem_ack)
            state_q <= ST_CALC;
        ST_CALC:
          state_q <= ST_DONE;
        ST_PUSH, ST_POP:
          if (mem_ack)
            state_q <= ST_DONE;
        ST_DONE:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operand capture
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      op_q <= OP_LOOKUP_SIGNED_ROUNDED;
      size_q <= SZ_BYTE;
      frac_q <= `FRAC_ZERO;
      disp_q <= `RESET_WORD;
      lo_q <= `RESET_WORD;
      hi_q <= `RESET_WORD;
    end
    else
    begin
      if (accept)
      begin
        op_q <= op;
        size_q <= size;
        frac_q <= independent_variable_reg[`IVR_FRAC_MSB:`IVR_FRAC_LSB];
        disp_q <= link_disp;
        lo_q <= pair_lo;
        hi_q <= pair_hi;
      end
      if ((state_q == ST_READ_LO) && mem_ack)
        lo_q <= mem_rdata;
      if ((state_q == ST_READ_HI) && mem_ack)
        hi_q <= mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q <= `RESET_WORD;
      wdata_q <= `RESET_WORD;
      we_q <= 1'b0;
    end
    else if (accept)
    begin
      we_q <= (op == OP_FRAME_LINK);
      wdata_q <= frame_reg_in;
      if (op == OP_FRAME_LINK)
        addr_q <= sp_in - `SLOT_BYTES;
      else if (op == OP_FRAME_UNLINK)
        addr_q <= frame_reg_in;
      else
        addr_q <= table_base + ({24'h0, ofs} * size_step(size));
    end
    else if ((state_q == ST_READ_LO) && mem_ack)
      addr_q <= addr_q + size_step(size_q);
  end

  assign mem_req = (state_q == ST_READ_LO) || (state_q == ST_READ_HI) || (state_q == ST_PUSH)
    || (state_q == ST_POP);
  assign mem_we = we_q && (state_q == ST_PUSH);
  assign mem_addr = addr_q;
  assign mem_wdata = wdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic
  interp_calc u_calc (
    .entry_lo(lo_q),
    .entry_hi(hi_q),
    .frac(frac_q),
    .is_signed(op_is_signed(op_q)),
    .is_rounded(op_is_rounded(op_q)),
    .size(size_q),
    .value(calc_value)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      result_q <= `RESET_WORD;
    else if (state_q == ST_CALC)
      result_q <= calc_value;
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame pointer and stack pointer results
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sp_q <= `RESET_WORD;
      frame_q <= `RESET_WORD;
    end
    else if ((state_q == ST_PUSH) && mem_ack)
    begin
      frame_q <= addr_q;
      sp_q <= addr_q + disp_q;
    end
    else if ((state_q == ST_POP) && mem_ack)
    begin
      frame_q <= mem_rdata;
      sp_q <= addr_q + `SLOT_BYTES;
    end
  end

  assign busy = (state_q != ST_IDLE);
  assign done = (state_q == ST_DONE);
  assign result = result_q;
  assign sp_out = sp_q;
  assign frame_reg_out = frame_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_table_entry_addr: assert property (accept && op_is_lookup(op) && !from_regs |=> mem_req && !mem_we
    && mem_addr == $past(table_base) + {24'h0, $past(ofs)} * size_step($past(size)))
    else $error("first table entry address wrong");

  a_next_entry_addr: assert property ((state_q == ST_READ_LO) && mem_ack |=>
    mem_addr == $past(mem_addr) + size_step(size_q))
    else $error("second table entry not adjacent");

  a_pair_no_memory: assert property (accept && op_is_lookup(op) && from_regs |=> !mem_req ##1 done)
    else $error("register pair lookup touched memory or ran late");

  a_zero_frac_long: assert property ((state_q == ST_CALC) && op_q == OP_LOOKUP_SIGNED_ROUNDED
    && size_q == SZ_LONG && frac_q == `FRAC_ZERO |=> done && result == $past(lo_q))
    else $error("zero fraction does not return first entry");

  a_unrounded_signed: assert property ((state_q == ST_CALC) && op_q == OP_LOOKUP_SIGNED_UNROUNDED
    && size_q == SZ_BYTE && frac_q == `FRAC_ZERO |=>
    result == {{16{$past(lo_q[`BYTE_MSB])}}, $past(lo_q[`BYTE_MSB:0]), `FRAC_ZERO})
    else $error("signed unrounded layout wrong");

  a_unrounded_unsigned: assert property ((state_q == ST_CALC) && op_q == OP_LOOKUP_UNSIGNED_UNROUNDED
    && size_q == SZ_BYTE |=> result[31:16] == 16'h0 && result[7:0] == 8'($past(frac_q) * 8'($past(hi_q)
    - $past(lo_q))))
    else $error("unsigned unrounded fraction byte wrong");

  a_round_even: assert property ((state_q == ST_CALC) && op_q == OP_LOOKUP_UNSIGNED_ROUNDED
    && size_q == SZ_LONG && frac_q == `FRAC_HALF && lo_q != 32'hFFFFFFFF && hi_q == lo_q + 32'h1
    |=> result == ($past(lo_q[0]) ? $past(lo_q) + 32'h1 : $past(lo_q)))
    else $error("half way case not rounded to even");

  a_link_push: assert property (accept && op == OP_FRAME_LINK |=> mem_req && mem_we
    && mem_addr == $past(sp_in) - `SLOT_BYTES && mem_wdata == $past(frame_reg_in))
    else $error("frame link push wrong");

  a_link_result: assert property ((state_q == ST_PUSH) && mem_ack |=> done
    && frame_reg_out == $past(mem_addr) && sp_out == $past(mem_addr) + disp_q)
    else $error("frame link pointers wrong");

  a_unlink_pop: assert property (accept && op == OP_FRAME_UNLINK |=> mem_req && !mem_we
    && mem_addr == $past(frame_reg_in))
    else $error("frame unlink read address wrong");

  a_unlink_result: assert property ((state_q == ST_POP) && mem_ack |=> done
    && frame_reg_out == $past(mem_rdata) && sp_out == $past(mem_addr) + `SLOT_BYTES)
    else $error("frame unlink pointers wrong");

  a_done_pulse: assert property (done |=> !done && !busy)
    else $error("done held longer than one cycle");

  c_table_lookup: cover property (accept && !from_regs ##1 mem_req [*2] ##[1:20] done);
  c_pair_lookup: cover property (accept && from_regs && op == OP_LOOKUP_SIGNED_ROUNDED ##2 done);
  c_frame_link: cover property ((state_q == ST_PUSH) && mem_ack ##1 done);
  c_frame_unlink: cover property ((state_q == ST_POP) && mem_ack ##1 done);

endmodule

/* File: rtl/tbl_defs.svh */
// Operation
// - signed rounded lookup gives rounded signed integer
// - signed unrounded lookup keeps the fraction
// - unsigned rounded lookup gives rounded unsigned integer
// - unsigned unrounded lookup keeps the fraction
// - memory table, adjacent entries picked by offset
// - register pair endpoints interpolated as well
// - offset bits 15:8, fraction bits 7:0
// - result is lo plus fraction times difference/256
// - rounded variants round to nearest even
// - frame link pushes, records slot, reserves area
// - frame unlink loads stack pointer, then pops
`ifndef TBL_DEFS_SVH
`define TBL_DEFS_SVH

`define IVR_OFS_MSB 15
`define IVR_OFS_LSB 8
`define IVR_FRAC_MSB 7
`define IVR_FRAC_LSB 0
`define FRAC_W 8
`define FRAC_HALF 8'h80
`define FRAC_ZERO 8'h00
`define BYTE_MSB 7
`define WORD_MSB 15
`define LONG_MSB 31
`define STEP_BYTE 32'h1
`define STEP_WORD 32'h2
`define STEP_LONG 32'h4
`define SLOT_BYTES 32'h4
`define RESET_WORD 32'h0

`endif

/* File: rtl/tbl_pkg.sv */
`include "tbl_defs.svh"

package tbl_pkg;

  typedef enum logic [2:0] {
    OP_LOOKUP_SIGNED_ROUNDED,
    OP_LOOKUP_SIGNED_UNROUNDED,
    OP_LOOKUP_UNSIGNED_ROUNDED,
    OP_LOOKUP_UNSIGNED_UNROUNDED,
    OP_FRAME_LINK,
    OP_FRAME_UNLINK
  } op_t;

  typedef enum logic [1:0] {
    SZ_BYTE,
    SZ_WORD,
    SZ_LONG
  } size_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ_LO,
    ST_READ_HI,
    ST_CALC,
    ST_PUSH,
    ST_POP,
    ST_DONE
  } state_t;

  function automatic logic [31:0] size_step(input size_t sz);
    case (sz)
      SZ_BYTE: size_step = `STEP_BYTE;
      SZ_WORD: size_step = `STEP_WORD;
      default: size_step = `STEP_LONG;
    endcase
  endfunction

  function automatic logic op_is_lookup(input op_t op);
    op_is_lookup = (op != OP_FRAME_LINK) && (op != OP_FRAME_UNLINK);
  endfunction

  function automatic logic op_is_signed(input op_t op);
    op_is_signed = (op == OP_LOOKUP_SIGNED_ROUNDED) || (op == OP_LOOKUP_SIGNED_UNROUNDED);
  endfunction

  function automatic logic op_is_rounded(input op_t op);
    op_is_rounded = (op == OP_LOOKUP_SIGNED_ROUNDED) || (op == OP_LOOKUP_UNSIGNED_ROUNDED);
  endfunction

endpackage

/* File: rtl/interp_calc.sv */
`timescale 1ns/10ps
`include "tbl_defs.svh"

module interp_calc
  import tbl_pkg::*;
(
  input wire logic [31:0] entry_lo,
  input wire logic [31:0] entry_hi,
  input wire logic [7:0] frac,
  input wire logic is_signed,
  input wire logic is_rounded,
  input wire size_t size,
  output logic [31:0] value
);

  function automatic logic signed [47:0] extend(input logic [31:0] d, input size_t sz, input logic sgn);
    case (sz)
      SZ_BYTE: extend = sgn ? {{40{d[`BYTE_MSB]}}, d[`BYTE_MSB:0]} : {40'h0, d[`BYTE_MSB:0]};
      SZ_WORD: extend = sgn ? {{32{d[`WORD_MSB]}}, d[`WORD_MSB:0]} : {32'h0, d[`WORD_MSB:0]};
      default: extend = sgn ? {{16{d[`LONG_MSB]}}, d} : {16'h0, d};
    endcase
  endfunction

  logic signed [47:0] lo_x;
  logic signed [47:0] hi_x;
  logic signed [47:0] prod;
  logic signed [47:0] scaled;
  logic signed [47:0] whole;
  logic round_up;

  ////////////////////////////////////////////////////////////////////////////
  // interpolation in units of 1/256
  assign lo_x = extend(entry_lo, size, is_signed);
  assign hi_x = extend(entry_hi, size, is_signed);
  assign prod = (hi_x - lo_x) * $signed({40'h0, frac});
  assign scaled = (lo_x <<< `FRAC_W) + prod;
  assign whole = scaled >>> `FRAC_W;
  // nearest even: above half, or exactly half with odd integer
  assign round_up = scaled[`FRAC_W-1] && ((scaled[`FRAC_W-2:0] != 7'h0) || whole[0]);

  always_comb
  begin
    if (is_rounded)
      value = 32'(whole + {47'h0, round_up});
    else
      value = scaled[31:0];
  end

endmodule

/* File: testbench/table_lookup_interpolator_bench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED %0t got %h exp %h", $time, (a), (b)); end end

module table_lookup_interpolator_bench;
  import tbl_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic start = 1'h0;
  logic from_regs = 1'h0;
  logic mem_ack = 1'h0;
  op_t op = OP_LOOKUP_SIGNED_ROUNDED;
  size_t size = SZ_BYTE;
  logic [31:0] ivr = 32'h0, base = 32'h0, plo = 32'h0, phi = 32'h0, frm = 32'h0, spi = 32'h0, disp = 32'h0;
  logic [31:0] mem_rdata = 32'h0, wr_a, wr_d, mem_addr, mem_wdata, result, sp_out, frame_reg_out;
  logic mem_req, mem_we, busy, done;
  logic use_pair = 1'h0;
  logic [31:0] pair_a = 32'h0, pair_b = 32'h0;
  logic [7:0] fc [5] = '{8'h00, 8'h80, 8'h7F, 8'h81, 8'hFF};
  integer seed = 31550, miscompares = 0, n_tests = 0, cycles = 0, o, i;

  always #5 clk = ~clk;

  table_lookup_interpolator dut (.clk(clk), .rst(rst), .start(start), .op(op), .size(size), .from_regs(from_regs),
    .independent_variable_reg(ivr), .table_base(base), .pair_lo(plo), .pair_hi(phi), .frame_reg_in(frm),
    .sp_in(spi), .link_disp(disp), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .done(done),
    .result(result), .sp_out(sp_out), .frame_reg_out(frame_reg_out));

  ////////////////////////////////////////////////////////////////////////////////
  // memory side: random stalls, garbage while idle
  always @(negedge clk)
  begin
    mem_ack <= mem_req && ($random(seed) % 3 != 0);
    mem_rdata <= mem_req ? ent(mem_addr) : ~mem_rdata;
  end

  always @(posedge clk)
  begin
    if (mem_req && mem_we && mem_ack)
    begin
      wr_a <= mem_addr;
      wr_d <= mem_wdata;
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] ent(input logic [31:0] a);
    return a * 32'h9E3779B1 ^ 32'h5A5A1234;
  endfunction

  function automatic logic signed [63:0] ext(input logic [31:0] x, input logic sg, input int s);
    logic signed [63:0] t;
    int sh;
    sh = 64 - (8 << s);
    t = $signed({32'h0, x}) <<< sh;
    return sg ? (t >>> sh) : (t >> sh);
  endfunction

  function automatic logic [31:0] exp_lookup(input logic [31:0] lo, hi, input logic [7:0] f, input logic sg, rd,
                                             input int s);
    logic signed [63:0] a, b, v, ip;
    a = ext(lo, sg, s);
    b = ext(hi, sg, s);
    v = a * 64'sh100 + (b - a) * $signed({56'h0, f});
    ip = v >>> 8;
    if (rd && (v[7:0] > 8'h80 || (v[7:0] == 8'h80 && ip[0])))
      ip = ip + 64'sh1;
    return rd ? ip[31:0] : v[31:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic run(input int o, s, r, input logic [7:0] f, input logic fx);
    int k;
    logic [31:0] step, lo, hi, v;
    v = $random(seed);
    v[7:0] = f;
    if (f == 8'hFF)
      v[15:8] = 8'hFF;
    if (fx)
      v[15:0] = 16'hA380;
    ivr = v;
    base = $random(seed);
    lo = $random(seed);
    hi = $random(seed);
    plo = use_pair ? pair_a : (fx ? 32'h685 : lo);
    phi = use_pair ? pair_b : (fx ? 32'h68F : hi);
    frm = $random(seed);
    spi = $random(seed);
    disp = $random(seed);
    op = op_t'(o);
    size = size_t'(s);
    from_regs = r[0];
    start = 1'h1;
    @(negedge clk);
    `CHK(busy, 1'h1)
    for (k = 0; k < 60 && done !== 1'h1; k++)
    begin
      @(negedge clk);
      start = 1'h0;
    end
    `CHK(done, 1'h1)
    step = 32'h1 << s;
    lo = r ? plo : ent(base + ivr[15:8] * step);
    hi = r ? phi : ent(base + ivr[15:8] * step + step);
    if (o < 4)
      `CHK(result, exp_lookup(lo, hi, f, o < 2, o == 0 || o == 2, s))
    else if (o == 4)
    begin
      `CHK({wr_a, wr_d}, {spi - 32'h4, frm})
      `CHK({frame_reg_out, sp_out}, {spi - 32'h4, spi - 32'h4 + disp})
    end
    else
      `CHK({frame_reg_out, sp_out}, {ent(frm), frm + 32'h4})
    @(negedge clk);
    `CHK({done, busy}, 2'h0)
  endtask

  task automatic stop_test;
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(negedge clk);
    `CHK({busy, done, mem_req, mem_we}, 4'h0)
    `CHK({result, sp_out, frame_reg_out}, 96'h0)
    rst = 1'h0;
    run(2, 1, 1, 8'h80, 1'h1);
    `CHK(result, 32'h0000068A)
    $display("example test done");
    use_pair = 1'h1;
    pair_a = 32'h7FFFFFFE;
    pair_b = 32'h7FFFFFFF;
    run(2, 2, 1, 8'h80, 1'h0);
    `CHK(result, 32'h7FFFFFFE)
    pair_a = 32'h7FFFFFFF;
    pair_b = 32'h80000000;
    run(2, 2, 1, 8'h80, 1'h0);
    `CHK(result, 32'h80000000)
    use_pair = 1'h0;
    run(1, 0, 1, 8'($random(seed)), 1'h0);
    pair_a = result;
    run(1, 0, 1, 8'($random(seed)), 1'h0);
    pair_b = result;
    use_pair = 1'h1;
    run(0, 1, 1, 8'($random(seed)), 1'h0);
    use_pair = 1'h0;
    $display("corner tests done");
    for (o = 0; o < 6; o++)
    begin
      for (i = 0; i < 30; i++)
        run(o, i % 3, (i / 3) % 2, (i % 2) ? 8'($random(seed)) : fc[(i / 2) % 5], 1'h0);
      $display("op %0d tests done", o);
    end
    for (i = 0; i < 60; i++)
      run({$random(seed)} % 6, {$random(seed)} % 3, {$random(seed)} % 2, 8'($random(seed)), 1'h0);
    $display("mixed tests done");
    stop_test;
  end
endmodule
